// ### shared/skip_branch_pkg.sv
// Purpose: Shared types and constants for the conditional skip/branch unit
// Assumes: 16-bit word program counter, 8-bit status flags word
// Notes: Opcode enumeration is local to this unit, not an instruction encoding
package skip_branch_pkg;

  localparam int PC_W = 16;
  localparam int OFFSET_W = 7;
  localparam logic [2:0] FLAG_C_POS = 3'h0;
  localparam logic [2:0] FLAG_Z_POS = 3'h1;
  localparam logic [PC_W-1:0] PC_RESET = 16'h0000;
  localparam logic [PC_W-1:0] ONE_WORD = 16'h0001;
  localparam logic [PC_W-1:0] TWO_WORDS = 16'h0002;
  localparam logic [PC_W-1:0] THREE_WORDS = 16'h0003;
  localparam logic [1:0] CYC_BRANCH_TAKEN = 2'h2;
  localparam logic [1:0] CYC_SKIP_ONE_WORD = 2'h2;
  localparam logic [1:0] CYC_SKIP_TWO_WORD = 2'h3;
  localparam logic [1:0] CYC_PLAIN = 2'h1;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_SKIP_IF_REG_BIT_SET = 4'h1,
    OP_SKIP_IF_IO_BIT_CLEAR = 4'h2,
    OP_SKIP_IF_IO_BIT_SET = 4'h3,
    OP_BRANCH_IF_STATUS_BIT_SET = 4'h4,
    OP_BRANCH_IF_STATUS_BIT_CLEAR = 4'h5,
    OP_BRANCH_IF_EQUAL = 4'h6,
    OP_BRANCH_IF_NOT_EQUAL = 4'h7,
    OP_BRANCH_IF_CARRY_SET = 4'h8,
    OP_BRANCH_IF_CARRY_CLEAR = 4'h9,
    OP_BRANCH_IF_SAME_OR_HIGHER = 4'hA,
    OP_BRANCH_IF_LOWER = 4'hB
  } op_t;

  typedef struct packed {
    op_t op;
    logic [2:0] bit_sel;
    logic [7:0] operand;
    logic [OFFSET_W-1:0] offset;
    logic next_is_two_word;
  } instr_t;

  typedef struct packed {
    logic [PC_W-1:0] pc;
    logic [1:0] cycles;
    logic taken;
    logic [7:0] flags;
  } result_t;

endpackage

// ### verilog/cond_eval.sv
// Purpose: Pure condition evaluation for skip and branch operations
// Assumes: Operand is the general or I/O register value chosen by the decoder
// Notes: Combinational; flags are only read, never written
`timescale 1ns/1ps
`default_nettype none
module cond_eval (
  input wire skip_branch_pkg::op_t op,
  input wire logic [2:0] bit_sel,
  input wire logic [7:0] operand,
  input wire logic [7:0] status_flags_word,
  output logic hit,
  output logic is_skip
);

  // ==========================================
  // Bit and flag condition
  always_comb begin
    hit = 1'b0;
    is_skip = 1'b0;
    case (op)
      skip_branch_pkg::OP_SKIP_IF_REG_BIT_SET: begin
        is_skip = 1'b1;
        hit = operand[bit_sel]; // RULE1
      end
      skip_branch_pkg::OP_SKIP_IF_IO_BIT_CLEAR: begin
        is_skip = 1'b1;
        hit = ~operand[bit_sel]; // RULE2
      end
      skip_branch_pkg::OP_SKIP_IF_IO_BIT_SET: begin
        is_skip = 1'b1;
        hit = operand[bit_sel]; // RULE3
      end
      skip_branch_pkg::OP_BRANCH_IF_STATUS_BIT_SET: hit = status_flags_word[bit_sel]; // RULE4
      skip_branch_pkg::OP_BRANCH_IF_STATUS_BIT_CLEAR: hit = ~status_flags_word[bit_sel]; // RULE5
      skip_branch_pkg::OP_BRANCH_IF_EQUAL: begin
        hit = status_flags_word[skip_branch_pkg::FLAG_Z_POS]; // RULE6
      end
      skip_branch_pkg::OP_BRANCH_IF_NOT_EQUAL: begin
        hit = ~status_flags_word[skip_branch_pkg::FLAG_Z_POS]; // RULE7
      end
      skip_branch_pkg::OP_BRANCH_IF_CARRY_SET, skip_branch_pkg::OP_BRANCH_IF_LOWER: begin
        hit = status_flags_word[skip_branch_pkg::FLAG_C_POS]; // RULE8
      end
      skip_branch_pkg::OP_BRANCH_IF_CARRY_CLEAR: begin
        hit = ~status_flags_word[skip_branch_pkg::FLAG_C_POS]; // RULE9
      end
      skip_branch_pkg::OP_BRANCH_IF_SAME_OR_HIGHER: begin
        hit = ~status_flags_word[skip_branch_pkg::FLAG_C_POS]; // RULE10
      end
      default: begin
        hit = 1'b0;
        is_skip = 1'b0;
      end
    endcase
  end

endmodule
`default_nettype wire

// ### verilog/conditional_skip_branch_unit.sv
// Purpose: Program counter update for conditional skips and relative branches
// Assumes: One instruction presented per start pulse; decoder waits for done
// Notes: Cycle counts are modelled by a busy phase after the start cycle
//
// Behaviour
// (RULE1) Register bit set skips next instruction
// (RULE2) I/O bit clear skips next instruction
// (RULE3) I/O bit set skips next instruction
// (RULE4) Status bit set branches PC+k+1
// (RULE5) Status bit clear branches PC+k+1
// (RULE6) Zero flag set branches PC+k+1
// (RULE7) Zero flag clear branches PC+k+1
// (RULE8) Carry set or lower branches PC+k+1
// (RULE9) Carry clear branches PC+k+1
// (RULE10) Same or higher equals carry clear
// (RULE11) Cycles: branch 1/2, skip 1/2/3
`timescale 1ns/1ps
`default_nettype none
module conditional_skip_branch_unit #(
  parameter int PC_WIDTH = skip_branch_pkg::PC_W
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic start,
  input wire skip_branch_pkg::instr_t instr,
  input wire logic [PC_WIDTH-1:0] pc_in,
  input wire logic [7:0] status_flags_word,
  output logic busy,
  output logic done,
  output skip_branch_pkg::result_t result
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT1 = 3'b010,
    ST_WAIT2 = 3'b100
  } state_t;

  state_t state_q;
  state_t state_d;
  logic hit;
  logic is_skip;
  logic [1:0] cycles;
  logic [PC_WIDTH-1:0] pc_next;
  wire logic [PC_WIDTH-1:0] offset_ext;
  logic [skip_branch_pkg::PC_W-1:0] pc_q;
  logic [1:0] cycles_q;
  logic taken_q;
  logic [7:0] flags_q;
  logic done_q;
  logic accept;

  // ==========================================
  // Decode helpers
  // Word distance of a skip, measured from the skip itself
  function automatic logic [PC_WIDTH-1:0] skip_distance(input logic two_word);
    logic [PC_WIDTH-1:0] words;
    words = PC_WIDTH'(skip_branch_pkg::TWO_WORDS);
    if (two_word) begin
      words = PC_WIDTH'(skip_branch_pkg::THREE_WORDS);
    end
    return words;
  endfunction

  function automatic logic [1:0] skip_cycles(input logic two_word);
    logic [1:0] count;
    count = skip_branch_pkg::CYC_SKIP_ONE_WORD;
    if (two_word) begin
      count = skip_branch_pkg::CYC_SKIP_TWO_WORD;
    end
    return count;
  endfunction

  // Targets wrap at the top of program memory; no overflow is reported
  function automatic logic [PC_WIDTH-1:0] add_words(
    input logic [PC_WIDTH-1:0] base,
    input logic [PC_WIDTH-1:0] delta
  );
    logic [PC_WIDTH-1:0] sum;
    sum = base + delta;
    return sum;
  endfunction

  // Wait state entered after the start cycle; single-cycle work stays idle
  function automatic state_t first_wait(input logic [1:0] count);
    state_t wait_st;
    case (count)
      skip_branch_pkg::CYC_SKIP_TWO_WORD: wait_st = ST_WAIT2;
      skip_branch_pkg::CYC_BRANCH_TAKEN: wait_st = ST_WAIT1;
      default: wait_st = ST_IDLE;
    endcase
    return wait_st;
  endfunction

  function automatic logic ends_at_start(input logic [1:0] count);
    logic single;
    single = count == skip_branch_pkg::CYC_PLAIN;
    return single;
  endfunction

  function automatic logic is_idle(input state_t st);
    logic idle;
    idle = st == ST_IDLE;
    return idle;
  endfunction

  // ==========================================
  // Condition
  cond_eval u_cond (
    .op(instr.op),
    .bit_sel(instr.bit_sel),
    .operand(instr.operand),
    .status_flags_word(status_flags_word),
    .hit(hit),
    .is_skip(is_skip)
  );

  // ==========================================
  // Next program counter and cycle count
  // Offset is signed words; sign extension lets branches go backward
  assign offset_ext[skip_branch_pkg::OFFSET_W-1:0] = instr.offset;
  // Upper bits copy the sign bit of the offset
  for (genvar i = skip_branch_pkg::OFFSET_W; i < PC_WIDTH; i++) begin : g_sign_ext
    assign offset_ext[i] = instr.offset[skip_branch_pkg::OFFSET_W-1];
  end

  always_comb begin
    pc_next = add_words(pc_in, PC_WIDTH'(skip_branch_pkg::ONE_WORD));
    cycles = skip_branch_pkg::CYC_PLAIN;
    if (hit && is_skip) begin
      // Two or three words, by the length of the skipped instruction
      pc_next = add_words(pc_in, skip_distance(instr.next_is_two_word)); // RULE1 RULE2 RULE3
      cycles = skip_cycles(instr.next_is_two_word); // RULE11
    end else if (hit) begin
      // Branch target shares one adder for every branch form
      pc_next = add_words(pc_in,
        offset_ext + PC_WIDTH'(skip_branch_pkg::ONE_WORD)); // RULE4 RULE5 RULE6
      cycles = skip_branch_pkg::CYC_BRANCH_TAKEN; // RULE11
    end
  end

  // ==========================================
  // Cycle sequencing
  // Start is honoured only from idle, so a start seen only while busy is dropped
  assign accept = start && is_idle(state_q);

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (accept) begin
          state_d = first_wait(cycles); // RULE11
        end
      end
      ST_WAIT2: state_d = ST_WAIT1;
      ST_WAIT1: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  // ==========================================
  // State register
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d; // RULE11
    end
  end

  // ==========================================
  // Result, latched on the accepting edge and held until the next one
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pc_q <= skip_branch_pkg::PC_RESET;
    end else if (accept) begin
      pc_q <= skip_branch_pkg::PC_W'(pc_next); // RULE7 RULE8 RULE9 RULE10
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cycles_q <= 2'h0;
    end else if (accept) begin
      cycles_q <= cycles; // RULE11
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      taken_q <= 1'b0;
    end else if (accept) begin
      taken_q <= hit;
    end
  end

  // Flags are only copied, never written, so no instruction here disturbs them
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      flags_q <= 8'h00;
    end else if (accept) begin
      flags_q <= status_flags_word;
    end
  end

  // ==========================================
  // Done pulses in the last cycle of the instruction
  // The start cycle counts as the first, so plain work finishes at once
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      done_q <= 1'b0;
    end else begin
      done_q <= (accept && ends_at_start(cycles)) || state_q == ST_WAIT1; // RULE11
    end
  end

  // ==========================================
  // Outputs
  assign busy = !is_idle(state_q);
  assign done = done_q;
  assign result = '{pc: pc_q, cycles: cycles_q, taken: taken_q, flags: flags_q};

endmodule
`default_nettype wire

// ### sim/conditional_skip_branch_unit_monitor.sv
// Purpose: Port checks on the skip/branch unit
// Assumes: One clock, synchronous reset
// Notes: Bound to every unit instance
`timescale 1ns/1ps
`default_nettype none
module conditional_skip_branch_unit_monitor #(
  parameter int PC_WIDTH = 16
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic start,
  input wire skip_branch_pkg::instr_t instr,
  input wire logic [PC_WIDTH-1:0] pc_in,
  input wire logic [7:0] status_flags_word,
  input wire logic busy,
  input wire logic done,
  input wire skip_branch_pkg::result_t result
);
  // ==========
  // Checks
  wire logic acc;
  assign acc = start && !busy;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  a_flags_kept: assert property (acc |=> result.flags == $past(status_flags_word))
    else $error("flags altered");
  a_branch_target: assert property (acc && instr.op inside {[4'h4:4'hB]} |=>
    result.pc == PC_WIDTH'(result.taken ? $past(pc_in + PC_WIDTH'($signed(instr.offset))) + 1
    : $past(pc_in) + 1)) else $error("branch pc");
  a_skip_target: assert property (acc && instr.op inside {[4'h1:4'h3]} |=>
    result.pc == PC_WIDTH'($past(pc_in) + (result.taken ?
    ($past(instr.next_is_two_word) ? 3 : 2) : 1))) else $error("skip pc");
  a_branch_cycles: assert property (acc && instr.op inside {[4'h4:4'hB]} |=>
    result.cycles == (result.taken ? 2'h2 : 2'h1)) else $error("branch cycles");
  a_equal_cond: assert property (acc && instr.op == 4'h6 |=>
    result.taken == $past(status_flags_word[1])) else $error("zero test");
  a_carry_cond: assert property (acc && instr.op inside {4'h8, 4'hB} |=>
    result.taken == $past(status_flags_word[0])) else $error("carry test");
  a_ioset_cond: assert property (acc && instr.op == 4'h3 |=>
    result.taken == $past(instr.operand[instr.bit_sel])) else $error("io bit test");
  a_ioclr_cond: assert property (acc && instr.op == 4'h2 |=>
    result.taken == !$past(instr.operand[instr.bit_sel])) else $error("io clear test");
  a_ne_cond: assert property (acc && instr.op == 4'h7 |=>
    result.taken == !$past(status_flags_word[1])) else $error("not equal test");
  a_done_timing: assert property ((acc ##1 result.cycles == 2'h3) |->
    busy ##1 busy ##1 (done && !busy)) else $error("skip timing");
endmodule
bind conditional_skip_branch_unit conditional_skip_branch_unit_monitor #(.PC_WIDTH(PC_WIDTH))
  u_mon (.clk_sys(clk_sys), .reset(reset), .start(start), .instr(instr), .pc_in(pc_in),
  .status_flags_word(status_flags_word), .busy(busy), .done(done), .result(result));
`default_nettype wire

// ### sim/conditional_skip_branch_unit_tb.sv
// Purpose: Self-checking bench for the skip/branch unit
// Assumes: Rows run at pc 0100
// Notes: Expected pc worked out by hand
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin errors++; \
  $display("[ERR] %0t %h %h", $time, (a), (b)); end end
module conditional_skip_branch_unit_tb;
  // ==========
  // Rows: op bit operand k two flags pc cycles taken
  typedef struct packed {
    logic [3:0] o; logic [2:0] b; logic [7:0] v; logic [6:0] k; logic w;
    logic [7:0] f; logic [15:0] p; logic [1:0] c; logic t;
  } row_t;
  row_t rows [22] = '{
    '{4'h1, 3'h7, 8'h80, 7'h00, 1'h0, 8'h00, 16'h0102, 2'h2, 1'h1},
    '{4'h1, 3'h7, 8'h7F, 7'h00, 1'h0, 8'h00, 16'h0101, 2'h1, 1'h0},
    '{4'h2, 3'h0, 8'hFE, 7'h00, 1'h1, 8'h00, 16'h0103, 2'h3, 1'h1},
    '{4'h2, 3'h0, 8'h01, 7'h00, 1'h1, 8'h00, 16'h0101, 2'h1, 1'h0},
    '{4'h3, 3'h3, 8'h08, 7'h00, 1'h1, 8'h00, 16'h0103, 2'h3, 1'h1},
    '{4'h4, 3'h5, 8'h00, 7'h7F, 1'h0, 8'h20, 16'h0100, 2'h2, 1'h1},
    '{4'h5, 3'h5, 8'h00, 7'h7F, 1'h0, 8'h20, 16'h0101, 2'h1, 1'h0},
    '{4'h6, 3'h0, 8'h00, 7'h03, 1'h0, 8'h02, 16'h0104, 2'h2, 1'h1},
    '{4'h7, 3'h0, 8'h00, 7'h03, 1'h0, 8'h02, 16'h0101, 2'h1, 1'h0},
    '{4'h8, 3'h0, 8'h00, 7'h40, 1'h0, 8'h01, 16'h00C1, 2'h2, 1'h1},
    '{4'h9, 3'h0, 8'h00, 7'h3F, 1'h0, 8'h00, 16'h0140, 2'h2, 1'h1},
    '{4'hA, 3'h0, 8'h00, 7'h3F, 1'h0, 8'h01, 16'h0101, 2'h1, 1'h0},
    '{4'hB, 3'h0, 8'h00, 7'h01, 1'h0, 8'h01, 16'h0102, 2'h2, 1'h1},
    '{4'h0, 3'h0, 8'h00, 7'h00, 1'h0, 8'h00, 16'h0101, 2'h1, 1'h0},
    '{4'h5, 3'h2, 8'h00, 7'h05, 1'h0, 8'hFB, 16'h0106, 2'h2, 1'h1},
    '{4'h7, 3'h0, 8'h00, 7'h7E, 1'h0, 8'hFD, 16'h00FF, 2'h2, 1'h1},
    '{4'hA, 3'h0, 8'h00, 7'h10, 1'h0, 8'hFE, 16'h0111, 2'h2, 1'h1},
    '{4'h3, 3'h6, 8'hBF, 7'h00, 1'h0, 8'hFF, 16'h0101, 2'h1, 1'h0},
    '{4'h1, 3'h2, 8'h04, 7'h00, 1'h1, 8'h00, 16'h0103, 2'h3, 1'h1},
    '{4'h2, 3'h4, 8'hEF, 7'h00, 1'h0, 8'h00, 16'h0102, 2'h2, 1'h1},
    '{4'h9, 3'h0, 8'h00, 7'h05, 1'h0, 8'h01, 16'h0101, 2'h1, 1'h0},
    '{4'h6, 3'h0, 8'h00, 7'h05, 1'h0, 8'hFD, 16'h0101, 2'h1, 1'h0}};
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic start = 1'b0;
  skip_branch_pkg::instr_t instr = '0;
  logic [15:0] pc_in = 16'h0000;
  logic [7:0] status_flags_word = 8'h00;
  logic busy;
  logic done;
  skip_branch_pkg::result_t result;
  int errors = 0;
  int checks_done = 0;
  logic [2:0] n;
  conditional_skip_branch_unit #(.PC_WIDTH(16)) DUT (.clk_sys(clk_sys), .reset(reset),
    .start(start), .instr(instr), .pc_in(pc_in), .status_flags_word(status_flags_word),
    .busy(busy), .done(done), .result(result));
  initial forever #12.5 clk_sys = ~clk_sys;
  task automatic final_report();
    if (errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic drive(input row_t r);
    start <= 1'b1;
    instr <= '{skip_branch_pkg::op_t'(r.o), r.b, r.v, r.k, r.w};
    pc_in <= 16'h0100;
    status_flags_word <= r.f;
  endtask
  // Done is counted from the accepting edge, so n equals the cycle figure
  task automatic run(input row_t r);
    @(posedge clk_sys);
    drive(r);
    @(posedge clk_sys);
    start <= 1'b0;
    #1;
    `CHK(result.pc, r.p)
    `CHK(result.taken, r.t)
    `CHK(result.flags, r.f)
    `CHK(result.cycles, r.c)
    `CHK(busy, r.c != 2'h1)
    n = 3'h1;
    while (done !== 1'b1 && n < 3'h4) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    `CHK(n, {1'b0, r.c})
    `CHK(busy, 1'b0)
    if (n == 3'h4) final_report();
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    foreach (rows[i]) run(rows[i]);
    // Start while busy is dropped; the one held into the done cycle is taken
    @(posedge clk_sys);
    drive(rows[7]);
    @(posedge clk_sys);
    drive(rows[1]);
    @(posedge clk_sys);
    #1;
    `CHK(result.pc, 16'h0104)
    `CHK(busy, 1'b0)
    `CHK(done, 1'b1)
    @(posedge clk_sys);
    start <= 1'b0;
    #1;
    `CHK(result.pc, 16'h0101)
    `CHK(done, 1'b1)
    // Reset in mid skip clears everything
    @(posedge clk_sys);
    drive(rows[2]);
    @(posedge clk_sys);
    start <= 1'b0;
    reset <= 1'b1;
    @(posedge clk_sys);
    reset <= 1'b0;
    #1;
    `CHK({busy, done, result}, '0)
    final_report();
  end
endmodule
`default_nettype wire
